/* File: core/sfc_map.svh */
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// Opcodes
`define SFC_OP_STATUS_READ    8'h05
`define SFC_OP_STATUS_WRITE   8'h01
`define SFC_OP_ARRAY_WRITE    8'h02
`define SFC_OP_ARRAY_READ     8'h03
`define SFC_OP_FAST_READ      8'h0b
`define SFC_OP_SECTOR_STORE   8'h42
`define SFC_OP_SECTOR_FETCH   8'h4b
`define SFC_OP_IDENTITY_FETCH 8'h9f
`define SFC_OP_WRITE_UNLOCK   8'h06
`define SFC_OP_WRITE_LOCK     8'h04

// Status register fields
`define SFC_SR_PROTECT_PIN_EN 7
`define SFC_SR_FIXED_ONE      6
`define SFC_SR_GUARD_HIGH     3
`define SFC_SR_GUARD_LOW      2
`define SFC_SR_UNLOCK_LATCH   1
`define SFC_SR_RESET          8'h40

// Address space
`define SFC_ARRAY_AW          19
`define SFC_SECTOR_AW         8
`define SFC_ARRAY_TOP         19'h7ffff
`define SFC_GUARD_QUARTER     19'h60000
`define SFC_GUARD_HALF        19'h40000
`define SFC_ADDR_LAST_BYTE    2'd2
`define SFC_BIT_LAST          3'd7
`define SFC_ID_LAST           4'd8

`endif

/* File: core/sfc_pkg.sv */
`default_nettype none
`include "sfc_map.svh"

package sfc_pkg;

    typedef enum logic [2:0] {
        PH_CMD   = 3'b000,
        PH_ADDR  = 3'b001,
        PH_DUMMY = 3'b011,
        PH_DATA  = 3'b010,
        PH_SKIP  = 3'b110
    } sfc_phase_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_SR_RD, OP_SR_WR, OP_WR, OP_RD, OP_FRD, OP_SS_WR, OP_SS_RD, OP_ID
    } sfc_op_t;

    typedef struct packed {
        logic                     sec;
        logic [`SFC_ARRAY_AW-1:0] addr;
        logic [7:0]               data;
    } sfc_wentry_t;

    typedef struct packed {
        logic [1:0]               cs_m;
        logic                     cs_old;
        logic [1:0]               sck_m;
        logic                     sck_old;
        logic [1:0]               si_m;
        logic [1:0]               wp_m;
        sfc_phase_t               phase;
        sfc_op_t                  op;
        logic [2:0]               bit_cnt;
        logic [6:0]               rx_sr;
        logic [7:0]               tx_sr;
        logic                     so;
        logic [`SFC_ARRAY_AW-1:0] addr;
        logic [1:0]               addr_cnt;
        logic                     write_unlock_latch;
        logic                     protect_pin_enable;
        logic [1:0]               bp;
        logic                     clr_wel;
        logic                     halted;
        logic                     sr_done;
        logic [3:0]               id_idx;
        logic                     fetch;
        sfc_wentry_t              pend;
        logic                     wr_pend;
        sfc_wentry_t              buf0;
        sfc_wentry_t              buf1;
        logic [1:0]               buf_cnt;
    } sfc_state_t;

endpackage

`default_nettype wire

/* File: core/sfc_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.svh"

interface sfc_mem_if;
    logic                     rd_req;
    logic                     rd_sec;
    logic [`SFC_ARRAY_AW-1:0] rd_addr;
    logic [7:0]               rd_data;
    logic                     wr_valid;
    logic                     wr_ready;
    logic                     wr_sec;
    logic [`SFC_ARRAY_AW-1:0] wr_addr;
    logic [7:0]               wr_data;

    modport engine (output rd_req, rd_sec, rd_addr, wr_valid, wr_sec, wr_addr, wr_data,
                    input rd_data, wr_ready);
    modport store (input rd_req, rd_sec, rd_addr, wr_valid, wr_sec, wr_addr, wr_data,
                   output rd_data, wr_ready);
endinterface // sfc_mem_if

`default_nettype wire

/* File: core/sfc_store.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.svh"

module sfc_store #(
    parameter int ARRAY_AW  = `SFC_ARRAY_AW,
    parameter int SECTOR_AW = `SFC_SECTOR_AW
) (
    input wire logic  clk,
    input wire logic  reset_n,
    sfc_mem_if.store  mem
);
    import sfc_pkg::*;

    if (ARRAY_AW > `SFC_ARRAY_AW || SECTOR_AW > ARRAY_AW || SECTOR_AW < 1) begin : g_chk
        $error("sfc_store: unsupported address widths");
    end

    logic [7:0] main_mem [2**ARRAY_AW];
    logic [7:0] sect_mem [2**SECTOR_AW];

    // Reads take the port; writes wait
    assign mem.wr_ready = ~mem.rd_req;

    always_ff @(posedge clk) begin
        if (mem.wr_valid && mem.wr_ready) begin
            if (mem.wr_sec) begin
                sect_mem[mem.wr_addr[SECTOR_AW-1:0]] <= mem.wr_data;
            end else begin
                main_mem[mem.wr_addr[ARRAY_AW-1:0]] <= mem.wr_data;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem.rd_data <= 8'h00;
        end else if (mem.rd_req) begin
            mem.rd_data <= mem.rd_sec ? sect_mem[mem.rd_addr[SECTOR_AW-1:0]]
                                      : main_mem[mem.rd_addr[ARRAY_AW-1:0]];
        end
    end
endmodule // sfc_store

`default_nettype wire

/* File: core/sfc_engine.sv */
// What this block does
// R01 - Status read returns current status byte
// R02 - Status write loads pin enable, guards
// R03 - Protect pin never blocks array writes
// R04 - Status write needs unlock, then clears it
// R05 - Three address bytes, low 19 bits used
// R06 - Address increments per byte, wraps to zero
// R07 - Input bytes arrive MSB first, eight clocks
// R08 - Each byte commits after eighth clock
// R09 - Guarded address stops burst, drops rest
// R10 - Select rising ends write commands
// R11 - Read data follows address, input ignored
// R12 - Select rising ends read, output floats
// R13 - Fast read adds one dummy byte
// R14 - Host avoids dummy byte upper nibble 1010
// R15 - Sector write: unlock, eight-bit address, sequential
// R16 - Host ends sector access at last byte
// R17 - Sector read streams from eight-bit address
// R18 - Identity read sends nine bytes, LSB first
// R19 - Upper 56 bits: six continuations, maker
// R20 - Product bytes hold fixed fields
// R21 - Latch clears at select rising after writes
// R22 - Guard codes protect quarter, half, all
// R23 - Enabled pin low rejects status writes
// R24 - Status bits fixed: 0,4,5 zero, 6 one
// R25 - Unknown opcode ignored, output stays floating
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.svh"

module sfc_engine #(
    parameter logic [7:0] MAKER_CONT = 8'h5a,   // Arbitrary value
    parameter logic [7:0] MAKER_CODE = 8'h3c,   // Arbitrary value
    parameter logic [2:0] FAMILY     = 3'h1,
    parameter logic [3:0] DENSITY    = 4'h2,
    parameter logic       INRUSH     = 1'b0,
    parameter logic [2:0] SUBTYPE    = 3'h1,
    parameter logic [1:0] REVISION   = 2'h0,
    parameter logic       VOLTAGE    = 1'b0,
    parameter logic [1:0] FREQUENCY  = 2'h1
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic wp_n,
    output var  logic so,
    output var  logic so_oe
);
    import sfc_pkg::*;
    if (MAKER_CONT == MAKER_CODE) begin : g_chk
        $error("sfc_engine: maker byte must differ from continuation byte");
    end
    localparam sfc_state_t ST_RST = '{cs_m: 2'b11, cs_old: 1'b1, phase: PH_CMD,
                                      op: OP_NONE, default: '0};
    localparam logic [71:0] ID_WORD = {MAKER_CODE, {6{MAKER_CONT}}, // [R19]
        FAMILY, DENSITY, INRUSH, SUBTYPE, REVISION, VOLTAGE, FREQUENCY}; // [R20]

    sfc_state_t               st_q;
    sfc_state_t               st_d;
    logic                     cs_hi;
    logic                     cs_rise;
    logic                     sck_rise;
    logic                     sck_fall;
    logic                     byte_done;
    logic [7:0]               rx_byte;
    logic [7:0]               status_byte;
    logic [`SFC_ARRAY_AW-1:0] full_addr;
    logic [`SFC_ARRAY_AW-1:0] next_addr;
    logic                     rd_req;
    logic                     rd_sec;
    logic [`SFC_ARRAY_AW-1:0] rd_addr;
    logic                     new_push;
    logic                     push_ok;
    logic                     pop;
    sfc_mem_if mem ();
    sfc_store #(.ARRAY_AW(`SFC_ARRAY_AW), .SECTOR_AW(`SFC_SECTOR_AW)) u_store (
        .clk     (clk),
        .reset_n (reset_n),
        .mem     (mem)
    );
    function automatic logic guarded(input logic [1:0] bp, input logic [`SFC_ARRAY_AW-1:0] a);
        unique case (bp)
            2'b01:   guarded = (a >= `SFC_GUARD_QUARTER); // [R22]
            2'b10:   guarded = (a >= `SFC_GUARD_HALF);    // [R22]
            2'b11:   guarded = 1'b1;                      // [R22]
            default: guarded = 1'b0;
        endcase
    endfunction
    function automatic logic is_read(input sfc_op_t op);
        is_read = (op == OP_SR_RD) || (op == OP_RD) || (op == OP_FRD) ||
                  (op == OP_SS_RD) || (op == OP_ID);
    endfunction
    assign mem.rd_req   = rd_req;
    assign mem.rd_sec   = rd_sec;
    assign mem.rd_addr  = rd_addr;
    assign mem.wr_valid = (st_q.buf_cnt != 2'd0);
    assign mem.wr_sec   = st_q.buf0.sec;
    assign mem.wr_addr  = st_q.buf0.addr;
    assign mem.wr_data  = st_q.buf0.data;
    assign so    = st_q.so;
    assign so_oe = ~st_q.cs_m[1] && st_q.phase == PH_DATA && is_read(st_q.op); // [R12] [R25]
    always_comb begin
        st_d      = st_q;
        st_d.cs_m = {st_q.cs_m[0], cs_n};
        st_d.sck_m = {st_q.sck_m[0], sck};
        st_d.si_m = {st_q.si_m[0], si};
        st_d.wp_m = {st_q.wp_m[0], wp_n};
        st_d.cs_old  = st_q.cs_m[1];
        st_d.sck_old = st_q.sck_m[1];
        st_d.fetch   = 1'b0;
        cs_hi     = st_q.cs_m[1];
        cs_rise   = cs_hi & ~st_q.cs_old;
        sck_rise  = st_q.sck_m[1] & ~st_q.sck_old & ~cs_hi;
        sck_fall  = ~st_q.sck_m[1] & st_q.sck_old & ~cs_hi;
        rx_byte   = {st_q.rx_sr, st_q.si_m[1]};               // [R07]
        byte_done = sck_rise && st_q.bit_cnt == `SFC_BIT_LAST;
        status_byte = 8'h00;
        status_byte[`SFC_SR_PROTECT_PIN_EN] = st_q.protect_pin_enable;
        status_byte[`SFC_SR_FIXED_ONE]      = 1'b1;          // [R24]
        status_byte[`SFC_SR_GUARD_HIGH]     = st_q.bp[1];
        status_byte[`SFC_SR_GUARD_LOW]      = st_q.bp[0];
        status_byte[`SFC_SR_UNLOCK_LATCH]   = st_q.write_unlock_latch;
        full_addr = {st_q.addr[`SFC_ARRAY_AW-9:0], rx_byte};  // [R05]
        next_addr = st_q.addr + 19'd1;                        // [R06]
        if (st_q.op == OP_SS_RD || st_q.op == OP_SS_WR) begin
            next_addr = {st_q.addr[`SFC_ARRAY_AW-1:8], st_q.addr[7:0] + 8'd1}; // [R15] [R17]
        end
        rd_req   = 1'b0;
        rd_sec   = (st_q.op == OP_SS_RD);
        rd_addr  = st_q.addr;
        new_push = 1'b0;

        if (st_q.fetch) begin
            st_d.tx_sr = mem.rd_data;
        end
        if (sck_fall && st_q.phase == PH_DATA && is_read(st_q.op)) begin
            st_d.so    = st_q.tx_sr[7];
            st_d.tx_sr = {st_q.tx_sr[6:0], 1'b0};
        end
        if (sck_rise) begin
            st_d.bit_cnt = st_q.bit_cnt + 3'd1;
            st_d.rx_sr   = rx_byte[6:0];
        end

        if (byte_done) begin
            unique case (st_q.phase)
                PH_CMD: begin
                    st_d.phase = PH_ADDR;
                    st_d.so    = 1'b0;
                    unique case (rx_byte)
                        `SFC_OP_STATUS_READ: begin
                            st_d.op    = OP_SR_RD;
                            st_d.phase = PH_DATA;
                            st_d.tx_sr = status_byte;         // [R01]
                        end
                        `SFC_OP_STATUS_WRITE: begin
                            st_d.op      = OP_SR_WR;
                            st_d.phase   = PH_DATA;
                            st_d.clr_wel = 1'b1;              // [R04]
                        end
                        `SFC_OP_ARRAY_WRITE: begin
                            st_d.op      = OP_WR;
                            st_d.clr_wel = 1'b1;
                        end
                        `SFC_OP_ARRAY_READ:  st_d.op = OP_RD;
                        `SFC_OP_FAST_READ:   st_d.op = OP_FRD;
                        `SFC_OP_SECTOR_STORE: begin
                            st_d.op      = OP_SS_WR;
                            st_d.clr_wel = 1'b1;
                        end
                        `SFC_OP_SECTOR_FETCH: st_d.op = OP_SS_RD;
                        `SFC_OP_IDENTITY_FETCH: begin
                            st_d.op     = OP_ID;
                            st_d.phase  = PH_DATA;
                            st_d.tx_sr  = ID_WORD[7:0];       // [R18]
                            st_d.id_idx = 4'd1;
                        end
                        `SFC_OP_WRITE_UNLOCK: begin
                            st_d.write_unlock_latch   = 1'b1;
                            st_d.phase = PH_SKIP;
                        end
                        `SFC_OP_WRITE_LOCK: begin
                            st_d.clr_wel = 1'b1;
                            st_d.phase   = PH_SKIP;
                        end
                        default: st_d.phase = PH_SKIP;        // [R25]
                    endcase
                end
                PH_ADDR: begin
                    st_d.addr     = full_addr;
                    st_d.addr_cnt = st_q.addr_cnt + 2'd1;
                    if (st_q.addr_cnt == `SFC_ADDR_LAST_BYTE) begin
                        st_d.phase = PH_DATA;
                        if (st_q.op == OP_FRD) begin
                            st_d.phase = PH_DUMMY;            // [R13]
                        end else if (st_q.op == OP_RD || st_q.op == OP_SS_RD) begin
                            rd_req     = 1'b1;                // [R11] [R17]
                            rd_addr    = full_addr;
                            st_d.fetch = 1'b1;
                        end
                    end
                end
                PH_DUMMY: begin
                    st_d.phase = PH_DATA;                     // [R13]
                    rd_req     = 1'b1;
                    st_d.fetch = 1'b1;
                end
                PH_DATA: begin
                    unique case (st_q.op)
                        OP_SR_WR: begin
                            st_d.sr_done = 1'b1;
                            if (!st_q.sr_done && st_q.write_unlock_latch &&
                                !(st_q.protect_pin_enable && !st_q.wp_m[1])) begin // [R23] [R04]
                                st_d.protect_pin_enable = rx_byte[`SFC_SR_PROTECT_PIN_EN]; // [R02]
                                st_d.bp   = {rx_byte[`SFC_SR_GUARD_HIGH],
                                             rx_byte[`SFC_SR_GUARD_LOW]};
                            end
                        end
                        OP_WR: begin
                            if (st_q.write_unlock_latch && !st_q.halted) begin // [R03]
                                if (guarded(st_q.bp, st_q.addr)) begin
                                    st_d.halted = 1'b1;         // [R09]
                                end else begin
                                    new_push  = 1'b1;           // [R08]
                                    st_d.pend = '{sec: 1'b0, addr: st_q.addr, data: rx_byte};
                                    st_d.addr = next_addr;      // [R06]
                                end
                            end
                        end
                        OP_SS_WR: begin
                            if (st_q.write_unlock_latch) begin
                                new_push  = 1'b1;               // [R15]
                                st_d.pend = '{sec: 1'b1, addr: st_q.addr, data: rx_byte};
                                st_d.addr = next_addr;
                            end
                        end
                        OP_RD, OP_FRD, OP_SS_RD: begin
                            st_d.addr  = next_addr;             // [R06]
                            rd_req     = 1'b1;
                            rd_addr    = next_addr;
                            st_d.fetch = 1'b1;
                        end
                        OP_ID: begin
                            st_d.tx_sr  = ID_WORD[8*st_q.id_idx +: 8]; // [R18]
                            st_d.id_idx = (st_q.id_idx == `SFC_ID_LAST) ? 4'd0
                                                                        : st_q.id_idx + 4'd1;
                        end
                        default: st_d.tx_sr = status_byte;      // [R01]
                    endcase
                end
                PH_SKIP: st_d.phase = PH_SKIP;
                default: st_d.phase = PH_SKIP;
            endcase
        end

        st_d.wr_pend = st_q.wr_pend | new_push;
        pop     = (st_q.buf_cnt != 2'd0) && mem.wr_ready;
        push_ok = st_q.wr_pend && (st_q.buf_cnt != 2'd2);
        if (pop) begin
            st_d.buf0 = st_q.buf1;
        end
        if (push_ok) begin
            if ((st_q.buf_cnt - {1'b0, pop}) == 2'd0) begin
                st_d.buf0 = st_q.pend;
            end else begin
                st_d.buf1 = st_q.pend;
            end
            if (!new_push) begin
                st_d.wr_pend = 1'b0;
            end
        end
        st_d.buf_cnt = st_q.buf_cnt + {1'b0, push_ok} - {1'b0, pop};

        if (cs_hi) begin
            st_d.phase    = PH_CMD;                           // [R10] [R12]
            st_d.op       = OP_NONE;
            st_d.bit_cnt  = 3'd0;
            st_d.addr_cnt = 2'd0;
            st_d.halted   = 1'b0;
            st_d.sr_done  = 1'b0;
            if (cs_rise && st_q.clr_wel) begin
                st_d.write_unlock_latch     = 1'b0;                          // [R21]
                st_d.clr_wel = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_wbyte;
        byte_done && st_q.phase == PH_DATA && st_q.op == OP_WR && st_q.write_unlock_latch && !st_q.halted
            && !guarded(st_q.bp, st_q.addr);
    endsequence
    sequence s_committed;
        ##[1:6] (mem.wr_valid && mem.wr_ready && !mem.wr_sec);
    endsequence
    status_read_a: assert property (byte_done && st_q.phase == PH_CMD && // [R01]
        rx_byte == `SFC_OP_STATUS_READ |=> st_q.tx_sr == $past(status_byte))
        else $error("status byte not loaded");
    pin_block_a: assert property (byte_done && st_q.phase == PH_DATA && // [R23]
        st_q.op == OP_SR_WR && st_q.protect_pin_enable && !st_q.wp_m[1] |=> $stable(st_q.bp) && st_q.protect_pin_enable)
        else $error("status written while pin protected");
    commit_a: assert property (s_wbyte |-> s_committed) // [R08]
        else $error("array byte not committed");
    guard_drop_a: assert property (st_q.wr_pend && !st_q.pend.sec |-> // [R09]
        !guarded(st_q.bp, st_q.pend.addr)) else $error("guarded address written");
    addr_wrap_a: assert property (byte_done && st_q.phase == PH_DATA && st_q.op == OP_RD && // [R06]
        st_q.addr == `SFC_ARRAY_TOP |=> st_q.addr == 19'd0) else $error("address did not wrap");
    latch_clear_a: assert property (cs_rise && st_q.clr_wel |=> !st_q.write_unlock_latch[*2]) // [R21]
        else $error("unlock latch not cleared");
    float_end_a: assert property (cs_rise |-> !so_oe ##1 !so_oe) // [R12]
        else $error("output driven after select rising");
    unknown_op_a: assert property (st_q.phase == PH_SKIP |-> !so_oe) // [R25]
        else $error("output driven for ignored opcode");
    fixed_bits_a: assert property (status_byte[6] && !status_byte[0] && // [R24]
        status_byte[5:4] == 2'b00) else $error("fixed status bits wrong");
    id_order_a: assert property (byte_done && st_q.phase == PH_CMD && // [R18]
        rx_byte == `SFC_OP_IDENTITY_FETCH |=> st_q.tx_sr == ID_WORD[7:0])
        else $error("identity does not start at low byte");
    dummy_a: assert property (byte_done && st_q.phase == PH_ADDR && st_q.op == OP_FRD && // [R13]
        st_q.addr_cnt == `SFC_ADDR_LAST_BYTE |=> st_q.phase == PH_DUMMY && !so_oe)
        else $error("fast read skipped dummy byte");
endmodule // sfc_engine

`default_nettype wire

/* File: sim/sfc_host.sv */
`timescale 1ns/1ps
`default_nettype none

module sfc_host (
    input  wire logic clk,
    output var  logic cs_n,
    output var  logic sck,
    output var  logic si,
    input  wire logic so,
    input  wire logic so_oe
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    task automatic sel(input logic v);
        if (v) begin
            half();
            cs_n = 1'b1;
            si   = ~si; // Released line shows no stale bit
            repeat (8) @(negedge clk);
        end else begin
            cs_n = 1'b0;
            half();
        end
    endtask

    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            si = tx[i]; // MSB first
            half();
            sck   = 1'b1;
            rx[i] = so_oe ? so : ~so; // Undriven line reads inverted
            half();
            sck   = 1'b0;
        end
    endtask
endmodule // sfc_host

`default_nettype wire

/* File: sim/sfc_engine_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module sfc_engine_bench;
    logic        clk       = 1'b0;
    logic        reset_n   = 1'b0;
    logic        wp_n      = 1'b1;
    logic        cs_n;
    logic        sck;
    logic        si;
    logic        so;
    logic        so_oe;
    logic [7:0]  rx [12];
    int          err_total = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    logic [39:0] rows [5]  = '{40'h03_000010_a5, 40'h0b_f80020_5a, 40'h03_07ffff_c3,
                               40'h0b_000000_81, 40'h03_060000_e7};
    logic [71:0] id_exp    = {8'h3c, {6{8'h5a}}, 8'h24, 8'h21};

    always #10 clk = ~clk;

    sfc_engine uut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
                    .wp_n(wp_n), .so(so), .so_oe(so_oe));
    sfc_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic fr(input int n, input logic [95:0] v, input bit close = 1'b1);
        host.sel(1'b0);
        for (int i = 0; i < n; i++) begin
            host.xfer(v[8*(n-1-i) +: 8], 8, rx[i]);
        end
        if (close) begin
            host.sel(1'b1);
        end
    endtask

    task automatic unl();
        fr(1, 96'h06); // Unlock in its own frame
    endtask

    task automatic sr(input logic [7:0] exp);
        fr(2, 96'h0500);
        chk("status", rx[1], exp);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("so_oe", {7'h0, so_oe}, 8'h00);
        sr(8'h40);
        done("reset");
        foreach (rows[i]) begin
            unl();
            fr(5, {8'h02, rows[i][31:0]});
            fr(6, {rows[i][39:32], 5'h00, rows[i][26:8], 16'h0000}); // Zero dummy
            chk("array", rx[rows[i][39:32] == 8'h0b ? 5 : 4], rows[i][7:0]);
        end
        done("rows");
        unl();
        fr(7, {8'h02, 24'h07fffe, 24'h112233});
        fr(7, {8'h03, 24'h07fffe, 24'h0});
        for (int i = 0; i < 3; i++) chk("wrap", rx[4+i], 8'(8'h11 * (i + 1)));
        done("wrap");
        fr(2, 96'h018c);
        sr(8'h40);
        unl();
        sr(8'h42);
        fr(1, 96'h04); // Lock clears latch at select rising
        sr(8'h40);
        unl();
        fr(2, 96'h01ff);
        sr(8'hcc);
        wp_n = 1'b0;
        unl();
        fr(2, 96'h0184);
        sr(8'hcc);
        wp_n = 1'b1;
        unl();
        fr(2, 96'h0184);
        sr(8'hc4);
        wp_n = 1'b0;
        unl();
        fr(8, {8'h02, 24'h05fffe, 32'h44556677});
        fr(7, {8'h03, 24'h05fffe, 24'h0});
        chk("guard", rx[4], 8'h44);
        chk("guard", rx[5], 8'h55);
        chk("guard", rx[6], 8'he7);
        wp_n = 1'b1;
        done("protect");
        unl();
        fr(5, {8'h02, 24'h00000f, 8'h6e}, 1'b0);
        host.xfer(8'hff, 4, rx[0]);
        host.sel(1'b1);
        fr(6, {8'h03, 24'h00000f, 16'h0});
        chk("partial", rx[4], 8'h6e);
        chk("partial", rx[5], 8'ha5);
        done("partial");
        unl();
        fr(6, {8'h42, 24'h1234fe, 16'h9abc}); // Ends at last sector byte
        fr(6, {8'h42, 24'h0000fe, 16'h0101});
        fr(6, {8'h4b, 24'hff00fe, 16'h0}, 1'b0);
        chk("so_oe", {7'h0, so_oe}, 8'h01);
        host.sel(1'b1);
        chk("so_oe", {7'h0, so_oe}, 8'h00);
        chk("sector", rx[4], 8'h9a);
        chk("sector", rx[5], 8'hbc);
        done("sector");
        fr(10, {8'h9f, 72'h0});
        for (int i = 0; i < 9; i++) chk("identity", rx[1+i], id_exp[8*i +: 8]);
        done("identity");
        fr(3, 96'h770000, 1'b0);
        chk("so_oe", {7'h0, so_oe}, 8'h00);
        host.sel(1'b1);
        done("unknown");
        fr(6, {8'h03, 24'h00000f, 16'h0}, 1'b0); // Reset in mid-read
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("so_oe", {7'h0, so_oe}, 8'h00);
        host.sel(1'b1);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        sr(8'h40);
        done("reset mid-run");
        report_and_stop();
    end
endmodule // sfc_engine_bench

`default_nettype wire
